// ---- rct_pkg.sv ----
/*
 * Package for the reset cause tracker: register offsets, flag bit positions,
 * reset values and timing counts.
 * Assumes a 32-bit APB bus with word-aligned registers.
 */
package rct_pkg;
   // Register byte offsets
   localparam logic [11:0] ADDR_FLAGS  = 12'h000;
   localparam logic [11:0] ADDR_ISTAT  = 12'h004;
   localparam logic [11:0] ADDR_IMASK  = 12'h008;
   localparam logic [11:0] ADDR_CTRL   = 12'h00C;
   localparam logic [11:0] ADDR_STATE  = 12'h010;
   localparam logic [11:0] ADDR_IDENT  = 12'h014;

   // Flag bit positions
   localparam int BIT_POR    = 0;
   localparam int BIT_BOR    = 1;
   localparam int BIT_IDLE   = 2;
   localparam int BIT_SLEEP  = 3;
   localparam int BIT_WATCHDOG_TIMEOUT_FLAG   = 4;
   localparam int BIT_SOFT   = 6;
   localparam int BIT_PIN    = 7;
   localparam int BIT_CM     = 9;
   localparam int BIT_ILL    = 14;
   localparam int BIT_TRAP   = 15;

   // Implemented flag bits
   localparam logic [15:0] FLAGS_IMPL  = 16'hC2DF;
   localparam logic [15:0] FLAGS_RST   = 16'h0003;

   // Interrupt status bits
   localparam int EV_SOFT   = 0;
   localparam int EV_WATCHDOG_TIMEOUT_FLAG   = 1;
   localparam int EV_TRAP   = 2;
   localparam int EV_CM     = 3;
   localparam int EV_ILL    = 4;
   localparam int EV_WAKE   = 5;
   localparam int EV_NUM    = 6;

   // Control register bits
   localparam int CTRL_CM_EN = 0;
   localparam logic [31:0] CTRL_RST = 32'h0000_0001;

   // Hard trap priority band
   localparam logic [3:0] HARD_TRAP_MIN = 4'hD;
   localparam logic [3:0] HARD_TRAP_MAX = 4'hF;

   // Illegal opcode upper byte
   localparam logic [7:0] ILLEGAL_OPCODE_HI = 8'h3F;

   // Software reset pulse: one instruction cycle
   localparam int INSTR_CYCLE_NS = 10;
   localparam int CLK_PERIOD_NS  = 10;
   localparam int SOFT_RST_CYC   = (INSTR_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // Identity value (arbitrary)
   localparam logic [31:0] IDENT_VALUE = 32'h5243_0001;
endpackage : rct_pkg

// ---- rct_tracker.sv ----
/*
 * Reset cause tracker: turns core reset events into a system reset request
 * and keeps the cause flags readable and writable over APB.
 * Assumes events arrive synchronous to pclk as one-cycle pulses or levels;
 * presetn is the warm reset of the bus side, por_n and bor_n mark cold events.
 *
 */
`timescale 1ns/1ps
`default_nettype none

module rct_tracker #(
   parameter int NUM_WREG  = 16,
   parameter int PPS_WIDTH = 32
) (
   input  wire logic                 pclk,
   input  wire logic                 presetn,
   input  wire logic                 por_n,
   input  wire logic                 bor_n,
   input  wire logic                 master_clear_pin_n,
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [11:0]          paddr,
   input  wire logic [31:0]          pwdata,
   input  wire logic [3:0]           pstrb,
   output logic      [31:0]          prdata,
   output logic                      pready,
   output logic                      pslverr,
   input  wire logic                 reset_instr,
   input  wire logic                 watchdog_timeout,
   input  wire logic                 watchdog_clear_instruction,
   input  wire logic                 power_save_sleep,
   input  wire logic                 power_save_idle,
   input  wire logic                 core_asleep,
   input  wire logic                 trap_active,
   input  wire logic [3:0]           trap_active_level,
   input  wire logic                 trap_new,
   input  wire logic [3:0]           trap_new_level,
   input  wire logic                 opcode_exec,
   input  wire logic [7:0]           opcode_hi,
   input  wire logic                 wreg_write,
   input  wire logic [3:0]           wreg_write_idx,
   input  wire logic                 wreg_ptr_use,
   input  wire logic [3:0]           wreg_ptr_idx,
   input  wire logic                 program_flow_change,
   input  wire logic                 vector_flow_change,
   input  wire logic                 target_restricted,
   input  wire logic [PPS_WIDTH-1:0] pps_regs,
   input  wire logic [PPS_WIDTH-1:0] pps_shadow,
   output logic                      system_reset_signal,
   output logic                      keep_clock_source,
   output logic                      wake_request,
   output logic                      irq
);

   ////////////////////////////////////////////////////////////////////////
   // Event decode

   localparam int EV_BITS = rct_pkg::EV_NUM;

   logic [15:0]         flags_r;
   logic [EV_BITS-1:0]  istat_r;
   logic [EV_BITS-1:0]  imask_r;
   logic [31:0]         ctrl_r;
   logic [NUM_WREG-1:0] wreg_init_r;
   logic                soft_rst_r;
   logic [7:0]          soft_cnt_r;
   logic                wake_r;

   logic ev_soft;
   logic ev_wdt_reset;
   logic ev_wdt_wake;
   logic ev_trap;
   logic ev_cm;
   logic ev_illop;
   logic ev_uninit;
   logic ev_secure;
   logic ev_ill;
   logic cold_n;

   assign cold_n       = por_n & bor_n;
   assign ev_soft      = reset_instr;
   assign ev_wdt_reset = watchdog_timeout & ~core_asleep;
   assign ev_wdt_wake  = watchdog_timeout & core_asleep;
   assign ev_trap      = trap_active & trap_new
                         & (trap_new_level >= rct_pkg::HARD_TRAP_MIN)
                         & (trap_new_level <= rct_pkg::HARD_TRAP_MAX)
                         & (trap_new_level < trap_active_level);
   assign ev_cm        = ctrl_r[rct_pkg::CTRL_CM_EN]
                         & (pps_regs != pps_shadow);
   assign ev_illop     = opcode_exec & (opcode_hi == rct_pkg::ILLEGAL_OPCODE_HI);
   assign ev_uninit    = wreg_ptr_use & ~wreg_init_r[wreg_ptr_idx];
   assign ev_secure    = (program_flow_change | vector_flow_change)
                         & target_restricted;
   assign ev_ill       = ev_illop | ev_uninit | ev_secure;

   ////////////////////////////////////////////////////////////////////////
   // System reset

   // Watchdog, trap, mismatch and illegal events assert combinationally so
   // the core stops in the same cycle; the software reset is a timed pulse.
   assign system_reset_signal = soft_rst_r | ev_wdt_reset | ev_trap
                                | ev_cm | ev_ill | ~cold_n | ~master_clear_pin_n;
   // Only cold resets reselect the configured clock source
   assign keep_clock_source   = cold_n;
   assign wake_request        = wake_r;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         soft_rst_r <= 1'b0;
         soft_cnt_r <= 8'h00;
      end else if (ev_soft) begin
         soft_rst_r <= 1'b1;
         soft_cnt_r <= 8'(rct_pkg::SOFT_RST_CYC);
      end else if (soft_cnt_r > 8'h01) begin
         soft_cnt_r <= soft_cnt_r - 8'h01;
      end else begin
         soft_rst_r <= 1'b0;
         soft_cnt_r <= 8'h00;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wake_r <= 1'b0;
      end else begin
         wake_r <= ev_wdt_wake;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Working register initialization tracking

   genvar gi;
   generate
      for (gi = 0; gi < NUM_WREG; gi++) begin : g_wreg
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               wreg_init_r[gi] <= (gi == NUM_WREG - 1);
            end else if (system_reset_signal) begin
               wreg_init_r[gi] <= (gi == NUM_WREG - 1);
            end else if (wreg_write && wreg_write_idx == 4'(gi)) begin
               wreg_init_r[gi] <= 1'b1;
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // APB slave

   logic       wr_acc;
   logic       rd_acc;
   logic       addr_ok;
   logic [31:0] wmask;

   assign pready  = 1'b1;
   assign wr_acc  = psel & penable & pwrite;
   assign rd_acc  = psel & penable & ~pwrite;
   assign addr_ok = paddr == rct_pkg::ADDR_FLAGS || paddr == rct_pkg::ADDR_ISTAT
                    || paddr == rct_pkg::ADDR_IMASK || paddr == rct_pkg::ADDR_CTRL
                    || paddr == rct_pkg::ADDR_STATE || paddr == rct_pkg::ADDR_IDENT;
   assign pslverr = psel & penable & ~addr_ok;
   assign wmask   = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (psel && !penable && !pwrite) begin
         unique case (paddr)
            rct_pkg::ADDR_FLAGS: prdata <= {16'h0000, flags_r};
            rct_pkg::ADDR_ISTAT: prdata <= 32'(istat_r);
            rct_pkg::ADDR_IMASK: prdata <= 32'(imask_r);
            rct_pkg::ADDR_CTRL:  prdata <= ctrl_r;
            rct_pkg::ADDR_STATE: prdata <= 32'(wreg_init_r);
            rct_pkg::ADDR_IDENT: prdata <= rct_pkg::IDENT_VALUE;
            default:             prdata <= 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_r  <= rct_pkg::CTRL_RST;
         imask_r <= '0;
      end else if (wr_acc) begin
         if (paddr == rct_pkg::ADDR_CTRL) begin
            ctrl_r <= (ctrl_r & ~wmask) | (pwdata & wmask & 32'h0000_0001);
         end
         if (paddr == rct_pkg::ADDR_IMASK) begin
            imask_r <= (imask_r & ~wmask[EV_BITS-1:0]) | (pwdata[EV_BITS-1:0] & wmask[EV_BITS-1:0]);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Reset cause flags

   logic [15:0] hw_set;
   logic [15:0] hw_clr;
   logic [15:0] sw_mask;
   logic        sw_wr;

   always_comb begin
      hw_set = 16'h0000;
      hw_set[rct_pkg::BIT_SOFT]  = ev_soft;
      hw_set[rct_pkg::BIT_WATCHDOG_TIMEOUT_FLAG]  = watchdog_timeout;
      hw_set[rct_pkg::BIT_TRAP]  = ev_trap;
      hw_set[rct_pkg::BIT_CM]    = ev_cm;
      hw_set[rct_pkg::BIT_ILL]   = ev_ill;
      hw_set[rct_pkg::BIT_PIN]   = ~master_clear_pin_n;
      hw_set[rct_pkg::BIT_SLEEP] = power_save_sleep;
      hw_set[rct_pkg::BIT_IDLE]  = power_save_idle;
      hw_clr = 16'h0000;
      hw_clr[rct_pkg::BIT_WATCHDOG_TIMEOUT_FLAG]  = watchdog_clear_instruction
                                   | power_save_sleep | power_save_idle;
   end

   assign sw_wr   = wr_acc && paddr == rct_pkg::ADDR_FLAGS;
   assign sw_mask = wmask[15:0] & rct_pkg::FLAGS_IMPL;

   // Cold events act as the master clears; hardware sets win over software
   // and over the watchdog clear instruction in the same cycle.
   always_ff @(posedge pclk) begin
      if (!por_n) begin
         flags_r <= rct_pkg::FLAGS_RST;
      end else if (!bor_n) begin
         flags_r <= (flags_r & (16'h0001 << rct_pkg::BIT_PIN))
                    | rct_pkg::FLAGS_RST & ~16'h0001 | (flags_r & 16'h0001);
      end else begin
         flags_r <= ((sw_wr ? ((flags_r & ~sw_mask) | (pwdata[15:0] & sw_mask))
                      : flags_r) & ~hw_clr | hw_set) & rct_pkg::FLAGS_IMPL;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Interrupt status and output

   logic [EV_BITS-1:0] ev_vec;
   logic [EV_BITS-1:0] istat_clr;

   assign ev_vec    = {ev_wdt_wake, ev_ill, ev_cm, ev_trap, ev_wdt_reset, ev_soft};
   assign istat_clr = (wr_acc && paddr == rct_pkg::ADDR_ISTAT)
                      ? (pwdata[EV_BITS-1:0] & wmask[EV_BITS-1:0]) : '0;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         istat_r <= '0;
      end else begin
         istat_r <= (istat_r & ~istat_clr) | ev_vec;
      end
   end

   assign irq = |(istat_r & imask_r);

endmodule : rct_tracker

`default_nettype wire

// ---- rct_tracker_properties.sv ----
/* Port checker for rct_tracker: reset causes, clock keeping and wake.
   Assumes events are one-cycle pulses sampled on pclk. */
`timescale 1ns/1ps
`default_nettype none
module rct_properties #(
   parameter int PPS_WIDTH = 32
) (
   input wire logic                 pclk,
   input wire logic                 presetn,
   input wire logic                 por_n,
   input wire logic                 bor_n,
   input wire logic                 master_clear_pin_n,
   input wire logic                 reset_instr,
   input wire logic                 watchdog_timeout,
   input wire logic                 core_asleep,
   input wire logic                 trap_active,
   input wire logic [3:0]           trap_active_level,
   input wire logic                 trap_new,
   input wire logic [3:0]           trap_new_level,
   input wire logic                 opcode_exec,
   input wire logic [7:0]           opcode_hi,
   input wire logic                 wreg_ptr_use,
   input wire logic                 program_flow_change,
   input wire logic                 vector_flow_change,
   input wire logic                 target_restricted,
   input wire logic [PPS_WIDTH-1:0] pps_regs,
   input wire logic [PPS_WIDTH-1:0] pps_shadow,
   input wire logic                 system_reset_signal,
   input wire logic                 keep_clock_source,
   input wire logic                 wake_request
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_soft_keeps_clock: assert property (reset_instr && por_n && bor_n |-> keep_clock_source)
      else $error("soft reset lost the clock source");
   a_soft_one_cycle: assert property (reset_instr |=> system_reset_signal)
      else $error("soft reset not raised next cycle");
   a_wdt_reset_now: assert property (watchdog_timeout && !core_asleep |-> system_reset_signal)
      else $error("watchdog time-out gave no reset");
   a_wdt_sleep_wake: assert property (watchdog_timeout && core_asleep |=> wake_request)
      else $error("watchdog time-out in sleep gave no wake");
   // Every other reset cause is excluded so that only the sleeping time-out is judged
   a_wdt_sleep_quiet: assert property (watchdog_timeout && core_asleep && por_n && bor_n && master_clear_pin_n
      && !trap_new && !opcode_exec && !wreg_ptr_use && !program_flow_change && !vector_flow_change
      && pps_regs == pps_shadow && !$past(reset_instr) |-> !system_reset_signal)
      else $error("watchdog time-out in sleep reset the core");
   a_trap_conflict: assert property (trap_active && trap_new && trap_new_level >= 4'hD
      && trap_new_level < trap_active_level |-> system_reset_signal)
      else $error("trap conflict gave no reset");
   a_bad_opcode: assert property (opcode_exec && opcode_hi == 8'h3F |-> system_reset_signal)
      else $error("illegal opcode gave no reset");
   a_secure_flow: assert property ((program_flow_change || vector_flow_change) && target_restricted
      |-> system_reset_signal)
      else $error("restricted flow change gave no reset");
endmodule : rct_properties
bind rct_tracker rct_properties #(.PPS_WIDTH(PPS_WIDTH)) u_props (.pclk, .presetn, .por_n, .bor_n,
   .master_clear_pin_n, .reset_instr, .watchdog_timeout, .core_asleep, .trap_active, .trap_active_level,
   .trap_new, .trap_new_level, .opcode_exec, .opcode_hi, .wreg_ptr_use, .program_flow_change,
   .vector_flow_change, .target_restricted, .pps_regs, .pps_shadow, .system_reset_signal,
   .keep_clock_source, .wake_request);
`default_nettype wire

// ---- test_reset_cause_tracker.sv ----
/* Self-checking bench for rct_tracker over APB with pulsed core events.
   Assumes zero-wait APB and flags preset to 0x0003 by por_n held low. */
`timescale 1ns/1ps
`default_nettype none
module test_reset_cause_tracker;
   logic pclk = 1'h0, presetn = 1'h0, por_n = 1'h0, bor_n = 1'h1, master_clear_pin_n = 1'h1;
   logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0, pready, pslverr, irq, wake_request;
   logic reset_instr = 1'h0, watchdog_timeout = 1'h0, watchdog_clear_instruction = 1'h0;
   logic power_save_sleep = 1'h0, power_save_idle = 1'h0, core_asleep = 1'h0, trap_active = 1'h0;
   logic trap_new = 1'h0, opcode_exec = 1'h0, wreg_write = 1'h0, wreg_ptr_use = 1'h0;
   logic program_flow_change = 1'h0, vector_flow_change = 1'h0, target_restricted = 1'h0;
   logic system_reset_signal, keep_clock_source;
   logic [11:0] paddr = 12'h0;
   logic [31:0] pwdata = 32'h0, prdata, pps_regs = 32'h0, pps_shadow = 32'h0, q;
   logic [3:0]  pstrb = 4'hF, trap_active_level = 4'hF, trap_new_level = 4'h0;
   logic [3:0]  wreg_write_idx = 4'h0, wreg_ptr_idx = 4'h0;
   logic [7:0]  opcode_hi = 8'h0;
   logic        s;
   int          err_count = 0, cmp_count = 0, cyc = 0;
   // Flags expected after each event of the table, negative cases last
   localparam logic [15:0] EXP [13] = '{16'h0040, 16'h0010, 16'h8000, 16'h0200, 16'h4000, 16'h4000,
      16'h4000, 16'h4000, 16'h0008, 16'h0004, 16'h0080, 16'h0000, 16'h0000};
   rct_tracker uut (.pclk, .presetn, .por_n, .bor_n, .master_clear_pin_n, .psel, .penable, .pwrite,
      .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .reset_instr, .watchdog_timeout,
      .watchdog_clear_instruction, .power_save_sleep, .power_save_idle, .core_asleep, .trap_active,
      .trap_active_level, .trap_new, .trap_new_level, .opcode_exec, .opcode_hi, .wreg_write,
      .wreg_write_idx, .wreg_ptr_use, .wreg_ptr_idx, .program_flow_change, .vector_flow_change,
      .target_restricted, .pps_regs, .pps_shadow, .system_reset_signal, .keep_clock_source,
      .wake_request, .irq);
   always #5 pclk = ~pclk;
   ////////////////////////////////////////////////////////////////////////////
   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : tally_and_finish
   always @(posedge pclk) begin
      cyc++;
      // Whole run needs well under a thousand cycles
      if (cyc == 5000) begin
         err_count++;
         tally_and_finish();
      end
   end
   task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         err_count++;
         $display("Error %s expected %h seen %h", n, exp, seen);
      end
   endtask : check
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      do @(posedge pclk); while (pready !== 1'h1);
      q = prdata;
      s = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      @(posedge pclk);
   endtask : apb
   task automatic rd(input logic [11:0] a, input logic [31:0] e, input string n);
      apb(1'h0, a, 32'h0);
      check(n, q, e);
   endtask : rd
   // One-cycle event; trap_active and target_restricted fall back with the pulse, trap_new_level and opcode_hi hold
   task automatic ev(input int k);
      trap_new_level <= (k == 2) ? 4'hD : 4'hC;
      opcode_hi <= (k == 4) ? 8'h3F : 8'h3E;
      target_restricted <= (k == 5 || k == 6);
      case (k)
         0: reset_instr <= 1'h1;
         1: watchdog_timeout <= 1'h1;
         2, 11: trap_new <= 1'h1;
         3: pps_regs <= 32'h1;
         4, 12: opcode_exec <= 1'h1;
         5: program_flow_change <= 1'h1;
         6: vector_flow_change <= 1'h1;
         7: wreg_ptr_use <= 1'h1;
         8: power_save_sleep <= 1'h1;
         9: power_save_idle <= 1'h1;
         13: watchdog_clear_instruction <= 1'h1;
         default: master_clear_pin_n <= 1'h0;
      endcase
      trap_active <= 1'h1;
      @(posedge pclk);
      {reset_instr, watchdog_timeout, trap_new, opcode_exec, program_flow_change} <= 5'h0;
      {vector_flow_change, wreg_ptr_use, power_save_sleep, power_save_idle, trap_active} <= 5'h0;
      {watchdog_clear_instruction, target_restricted, pps_regs} <= 34'h0;
      master_clear_pin_n <= 1'h1;
      @(posedge pclk);
   endtask : ev
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (3) @(posedge pclk);
      presetn <= 1'h1;
      @(posedge pclk);
      por_n <= 1'h1;
      @(posedge pclk);
      rd(12'h000, 32'h0003, "flags after power-on");
      apb(1'h0, 12'h020, 32'h0);
      check("unmapped error", {31'h0, s}, 32'h1);
      apb(1'h1, 12'h000, 32'hFFFF);
      rd(12'h000, 32'hC2DF, "flags all set");
      apb(1'h1, 12'h004, 32'h3F);
      $display("test registers done");
      for (int k = 0; k < 13; k++) begin
         apb(1'h1, 12'h000, 32'h0);
         ev(k);
         rd(12'h000, {16'h0, EXP[k]}, "flags after event");
      end
      rd(12'h004, 32'h1F, "event status");
      check("irq masked", {31'h0, irq}, 32'h0);
      apb(1'h1, 12'h008, 32'h1);
      check("irq unmasked", {31'h0, irq}, 32'h1);
      apb(1'h1, 12'h004, 32'h1F);
      check("irq cleared", {31'h0, irq}, 32'h0);
      $display("test events done");
      apb(1'h1, 12'h000, 32'h0);
      core_asleep <= 1'h1;
      ev(1);
      rd(12'h004, 32'h20, "wake status");
      rd(12'h000, 32'h10, "flags wdt in sleep");
      ev(13);
      rd(12'h000, 32'h0, "flags after wdt clear");
      ev(1);
      ev(8);
      rd(12'h000, 32'h8, "flags after sleep");
      core_asleep <= 1'h0;
      $display("test sleep done");
      apb(1'h1, 12'h000, 32'h0);
      ev(10);
      ev(0);
      bor_n <= 1'h0;
      @(posedge pclk);
      check("clock reselect on brown-out", {31'h0, keep_clock_source}, 32'h0);
      bor_n <= 1'h1;
      rd(12'h000, 32'h0082, "flags after brown-out");
      por_n <= 1'h0;
      @(posedge pclk);
      por_n <= 1'h1;
      rd(12'h000, 32'h0003, "flags after power-on");
      $display("test cold resets done");
      tally_and_finish();
   end
endmodule : test_reset_cause_tracker
`default_nettype wire
